// >>> rtl/sas_map.svh
// Constants for the serial converter sequencer: counts, codes, timings
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// Exchange framing
`define SAS_XFER_EDGES   4'h8
`define SAS_ADDR_EDGES   4'h4
`define SAS_LAST_FALL    4'h7

// Select filter, in accepted conversion clock rising edges
`define SAS_FILT_EDGES   2'h2

// Approximation: one trial per bit, each trial this many conversion clocks
`define SAS_TRIAL_CYC    3'h7
`define SAS_TRIAL_LAST   3'h6

// Sampling continues this long after the last falling edge
`define SAS_SAMPLE_NS    1000
`define SAS_CLK_NS       20
`define SAS_SAMPLE_CYC   ((`SAS_SAMPLE_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS)

// Address decode of the top nibble, and the result reset value
`define SAS_TEST_CODE    2'h3
`define SAS_RESULT_RST   8'h00

`endif

// >>> rtl/sas_pkg.sv
// Types for the serial converter sequencer
package sas_pkg;

  typedef enum logic [1:0] {
    SAS_IDLE   = 2'b00,
    SAS_XFER   = 2'b01,
    SAS_SAMPLE = 2'b10,
    SAS_CONV   = 2'b11
  } sas_state_t;

  typedef logic [3:0] sas_chan_t;

endpackage

// >>> rtl/sas_sequencer.sv
// Serial converter sequencer: select filter, exchange, sample window, approximation
`timescale 1ns/1ns
`include "sas_map.svh"

// Function
// (RL1) Select low enables serial lines; high ignores
// (RL2) Address in on rise, result out on fall
// (RL3) One exchange is exactly eight shift clocks
// (RL4) Host supplies conversion clock continuously
// (RL5) Select fall filtered one to three periods
// (RL6) Free-running clock: select low all eight cycles
// (RL7) Select fall drives result msb immediately
// (RL8) First four rises form the channel address
// (RL9) Last four cycles connect and sample input
// (RL10) Next seven falls shift low bits descending
// (RL11) Eighth fall starts 48 to 64 cycle conversion
// (RL12) Select high during conversion: float output, ignore clock
// (RL13) Select high alone keeps result valid
// (RL14) Select held low: next exchange right after conversion
// (RL15) Host raises select before 48th, lowers after 64th
// (RL16) Long select strobe aborts conversion or exchange
// (RL17) Result after abort may be wrong once
// (RL18) Gated clock held low 64 conversion clocks
// (RL19) Select low in conversion: output held low
// (RL20) Conversion end with select low shows new msb
// (RL21) Address received most significant bit first
// (RL22) Codes twelve and up enter digital test mode
// (RL23) Sample 1 us after eighth fall, then hold
// (RL24) Top nibble decodes inputs, test level, test mode
// (RL25) Eighth fall shows address msb until conversion clears
// (RL26) Each completed exchange consumes the result

module sas_sequencer
  import sas_pkg::*;
#(
  parameter int unsigned RES_W = 8
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic             ce_in,
  input  wire logic             conv_clk_in,
  input  wire logic             select_n_in,
  input  wire logic             sclk_in,
  input  wire logic             serial_in_in,
  input  wire logic             comp_in,
  output logic                  serial_out_out,
  output logic                  serial_out_oe_out,
  output logic [RES_W-1:0]      approximation_register_out,
  output logic [3:0]            channel_out,
  output logic                  sample_out,
  output logic                  conv_busy_out,
  output logic                  result_valid_out,
  output logic                  test_mode_out,
  output logic [3:0]            lowest_analog_inputs_out,
  output logic [3:0]            lowest_analog_inputs_oe_out
);

  // ==========================================================
  // Declarations
  sas_state_t       state_reg;
  logic             sel_s1_reg;
  logic             sel_s2_reg;
  logic             sel_s3_reg;
  logic             sel_q_reg;
  logic             conv_s1_reg;
  logic             conv_s2_reg;
  logic             conv_s3_reg;
  logic             conv_q_reg;
  logic             conv_rise;
  logic             sel_f_reg;
  logic             sel_f_d_reg;
  logic             sel_start;
  logic [1:0]       filt_cnt_reg;
  logic             done_s1_reg;
  logic             done_s2_reg;
  logic             done_d_reg;
  logic             done_rise;
  logic             link_clr_reg;
  logic             eoc_seen_reg;
  logic [5:0]       samp_cnt_reg;
  logic [RES_W-1:0] sar_reg;
  logic [2:0]       bit_idx_reg;
  logic [2:0]       sub_reg;
  logic [RES_W-1:0] result_reg;
  logic             result_ok_reg;
  sas_chan_t        chan_reg;
  logic             test_mode_reg;
  // Link side
  logic [3:0]       rise_cnt_reg;
  logic [3:0]       fall_cnt_reg;
  logic [7:0]       io_sr_reg;
  sas_chan_t        chan_lnk_reg;
  logic             sample_lnk_reg;
  logic             do_lnk_reg;
  logic             done_lnk_reg;

  localparam logic [5:0] SAMPLE_CYC = 6'(`SAS_SAMPLE_CYC);

  // ==========================================================
  // Pin synchronisers
  // Three stages; a change is accepted once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sel_s3_reg <= 1'b1;
      sel_q_reg  <= 1'b1;
    end else if (ce_in) begin
      sel_s1_reg <= select_n_in;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      if (sel_s2_reg == sel_s3_reg) begin
        sel_q_reg <= sel_s3_reg;
      end
    end
  end

  // The conversion clock is slow enough to be sampled as a level
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      conv_s1_reg <= 1'b0;
      conv_s2_reg <= 1'b0;
      conv_s3_reg <= 1'b0;
      conv_q_reg  <= 1'b0;
    end else if (ce_in) begin
      conv_s1_reg <= conv_clk_in; // see (RL4)
      conv_s2_reg <= conv_s1_reg;
      conv_s3_reg <= conv_s2_reg;
      if (conv_s2_reg == conv_s3_reg) begin
        conv_q_reg <= conv_s3_reg;
      end
    end
  end

  assign conv_rise = ce_in && !conv_q_reg && conv_s2_reg && conv_s3_reg;

  // ==========================================================
  // Select filter
  // A level must persist across two accepted conversion edges, so spikes
  // shorter than one period never reach the sequencer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sel_f_reg    <= 1'b1;
      sel_f_d_reg  <= 1'b1;
      filt_cnt_reg <= 2'h0;
    end else if (ce_in) begin
      sel_f_d_reg <= sel_f_reg;
      if (sel_q_reg == sel_f_reg) begin
        filt_cnt_reg <= 2'h0;
      end else if (conv_rise) begin
        if (filt_cnt_reg == `SAS_FILT_EDGES - 2'h1) begin
          sel_f_reg    <= sel_q_reg; // see (RL5) see (RL16)
          filt_cnt_reg <= 2'h0;
        end else begin
          filt_cnt_reg <= filt_cnt_reg + 2'h1;
        end
      end
    end
  end

  assign sel_start = ce_in && sel_f_d_reg && !sel_f_reg;

  // ==========================================================
  // Exchange-done crossing
  // Level stays up until the link is cleared, so two stages suffice
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_d_reg  <= 1'b0;
    end else if (ce_in) begin
      done_s1_reg <= done_lnk_reg;
      done_s2_reg <= done_s1_reg;
      done_d_reg  <= done_s2_reg;
    end
  end

  assign done_rise = ce_in && done_s2_reg && !done_d_reg;

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= SAS_IDLE;
    end else if (ce_in) begin
      case (state_reg)
        SAS_IDLE: begin
          if (sel_start) begin
            state_reg <= SAS_XFER; // see (RL5)
          end
        end
        SAS_XFER: begin
          if (done_rise) begin
            state_reg <= SAS_SAMPLE; // see (RL11)
          end else if (sel_f_reg) begin
            state_reg <= SAS_IDLE; // see (RL16)
          end
        end
        SAS_SAMPLE: begin
          if (sel_start) begin
            state_reg <= SAS_XFER; // see (RL16)
          end else if (samp_cnt_reg == SAMPLE_CYC - 6'h1) begin
            state_reg <= SAS_CONV; // see (RL23)
          end
        end
        SAS_CONV: begin
          if (sel_start) begin
            state_reg <= SAS_XFER; // see (RL16)
          end else if (conv_rise && sub_reg == `SAS_TRIAL_LAST
                       && bit_idx_reg == 3'h0) begin
            // Held low: serial I/O resumes at once; high: wait for a fall
            state_reg <= sel_f_reg ? SAS_IDLE : SAS_XFER; // see (RL14)
          end
        end
        default: begin
          state_reg <= SAS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Sample window and link clear
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      samp_cnt_reg <= 6'h0;
      eoc_seen_reg <= 1'b0;
    end else if (ce_in) begin
      if (state_reg != SAS_SAMPLE) begin
        samp_cnt_reg <= 6'h0;
        eoc_seen_reg <= 1'b0;
      end else begin
        samp_cnt_reg <= samp_cnt_reg + 6'h1;
        if (conv_rise) begin
          eoc_seen_reg <= 1'b1;
        end
      end
    end
  end

  // Link logic runs only while an exchange is open; shared register keeps
  // the address msb until the first conversion clock after the exchange
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      link_clr_reg <= 1'b1;
    end else if (ce_in) begin
      link_clr_reg <= !((state_reg == SAS_XFER && !done_rise)
                        || (state_reg == SAS_SAMPLE && !eoc_seen_reg)
                        || done_rise); // see (RL25) see (RL12)
    end
  end

  // ==========================================================
  // Successive approximation
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sar_reg     <= `SAS_RESULT_RST;
      bit_idx_reg <= 3'h7;
      sub_reg     <= 3'h0;
    end else if (ce_in) begin
      if (state_reg != SAS_CONV) begin
        sar_reg     <= `SAS_RESULT_RST;
        bit_idx_reg <= 3'(RES_W - 1);
        sub_reg     <= 3'h0;
      end else if (conv_rise) begin
        if (sub_reg == 3'h0) begin
          sar_reg[bit_idx_reg] <= 1'b1;
        end
        if (sub_reg == `SAS_TRIAL_LAST) begin
          if (!comp_in) begin
            sar_reg[bit_idx_reg] <= 1'b0;
          end
          sub_reg     <= 3'h0;
          bit_idx_reg <= bit_idx_reg - 3'h1;
        end else begin
          sub_reg <= sub_reg + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // Result, address and test mode
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      result_reg    <= `SAS_RESULT_RST;
      result_ok_reg <= 1'b0;
    end else if (ce_in) begin
      if (state_reg == SAS_CONV && !sel_start && conv_rise
          && sub_reg == `SAS_TRIAL_LAST && bit_idx_reg == 3'h0) begin
        result_reg    <= {sar_reg[RES_W-1:1], comp_in}; // see (RL13)
        result_ok_reg <= 1'b1;
      end else if ((state_reg == SAS_XFER && sel_f_reg && !done_rise)
                   || (state_reg != SAS_IDLE && state_reg != SAS_XFER
                       && sel_start)) begin
        result_ok_reg <= 1'b0; // see (RL17)
      end else if (done_rise) begin
        result_ok_reg <= 1'b0; // see (RL26)
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chan_reg      <= 4'h0;
      test_mode_reg <= 1'b0;
    end else if (ce_in && done_rise) begin
      chan_reg      <= chan_lnk_reg; // see (RL24)
      test_mode_reg <= chan_lnk_reg[3:2] == `SAS_TEST_CODE; // see (RL22)
    end
  end

  // ==========================================================
  // Link domain: shift clock edges
  // Cleared whenever no exchange is open, except in the sample window until its
  // first conversion clock, so a stopped clock leaves nothing half-done behind
  always_ff @(posedge sclk_in or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      rise_cnt_reg   <= 4'h0;
      io_sr_reg      <= 8'h00;
      chan_lnk_reg   <= 4'h0;
      sample_lnk_reg <= 1'b0;
    end else if (!select_n_in && rise_cnt_reg != `SAS_XFER_EDGES) begin
      io_sr_reg    <= {io_sr_reg[6:0], serial_in_in}; // see (RL2) see (RL21)
      rise_cnt_reg <= rise_cnt_reg + 4'h1; // see (RL3)
      if (rise_cnt_reg == `SAS_ADDR_EDGES - 4'h1) begin
        chan_lnk_reg   <= {io_sr_reg[2:0], serial_in_in}; // see (RL8)
        sample_lnk_reg <= 1'b1; // see (RL9)
      end
    end
  end

  always_ff @(negedge sclk_in or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      fall_cnt_reg <= 4'h0;
      do_lnk_reg   <= 1'b0;
      done_lnk_reg <= 1'b0;
    end else if (!select_n_in && fall_cnt_reg < rise_cnt_reg) begin // see (RL1)
      fall_cnt_reg <= fall_cnt_reg + 4'h1;
      if (fall_cnt_reg == `SAS_LAST_FALL) begin
        do_lnk_reg   <= io_sr_reg[7]; // see (RL25)
        done_lnk_reg <= 1'b1; // see (RL11)
      end else begin
        do_lnk_reg <= result_reg[3'(RES_W - 2) - fall_cnt_reg[2:0]]; // see (RL10)
      end
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    if (!link_clr_reg) begin
      serial_out_out = (fall_cnt_reg == 4'h0) ? result_reg[RES_W-1] : do_lnk_reg;
    end else if (state_reg == SAS_IDLE) begin
      serial_out_out = result_reg[RES_W-1]; // see (RL7) see (RL20)
    end else begin
      serial_out_out = 1'b0; // see (RL19)
    end
  end

  // Select alone gates the driver, so the output floats without delay
  assign serial_out_oe_out          = !select_n_in; // see (RL1) see (RL12)
  assign approximation_register_out = sar_reg;
  assign channel_out                = chan_reg;
  assign sample_out                 = (sample_lnk_reg && !link_clr_reg)
                                      || state_reg == SAS_SAMPLE; // see (RL23)
  assign conv_busy_out              = state_reg == SAS_CONV;
  assign result_valid_out           = result_ok_reg;
  assign test_mode_out              = test_mode_reg;
  assign lowest_analog_inputs_out   = result_reg[3:0];
  assign lowest_analog_inputs_oe_out = {4{test_mode_reg}}; // see (RL22)

endmodule

// >>> testbench/sas_host_model.sv
// Host model: select, shift clock and address line
`timescale 1ns/1ns
module sas_host_model (
  input  wire logic serial_out_in,
  output logic      select_n_out,
  output logic      sclk_out,
  output logic      serial_in_out
);
  initial begin
    select_n_out  = 1'b1;
    sclk_out      = 1'b0;
    serial_in_out = 1'b0;
  end
  // =====
  // Exchange: d[8:1] line after select and each fall, d[0] after the eighth
  task automatic xfer(input logic [7:0] a, input bit keep, output logic [8:0] d);
    if (select_n_out) begin
      select_n_out = 1'b0;
      #2 d[8] = serial_out_in;
      #1000; // Filter plus setup before the first rise
    end else begin
      d[8] = serial_out_in;
    end
    for (int i = 0; i < 8; i++) begin
      serial_in_out = a[7-i];
      #14 sclk_out = 1'b1;
      #16 sclk_out = 1'b0; // Parked low between frames
      #2 d[7-i] = serial_out_in;
    end
    // Released line flips so a stale level cannot pass for data
    serial_in_out = ~serial_in_out;
    if (!keep) begin
      #200 select_n_out = 1'b1;
    end
  endtask
  task automatic set_sel(input logic v, input int ns);
    select_n_out = v;
    #(ns);
  endtask
endmodule

// >>> testbench/sas_sequencer_checker.sv
// Port checker of the converter sequencer
`timescale 1ns/1ns
module sas_sequencer_checker (
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire logic       conv_clk_in,
  input wire logic       select_n_in,
  input wire logic       serial_out_out,
  input wire logic       serial_out_oe_out,
  input wire logic [3:0] channel_out,
  input wire logic       sample_out,
  input wire logic       conv_busy_out,
  input wire logic       result_valid_out,
  input wire logic       test_mode_out,
  input wire logic [3:0] lowest_analog_inputs_oe_out
);
  // =====
  // Conversion clock rises counted from conversion start
  logic       cc_reg;
  logic       busy_reg;
  logic [6:0] cnt_reg;
  always_ff @(posedge clk_in) begin
    cc_reg   <= conv_clk_in;
    busy_reg <= conv_busy_out;
  end
  always_ff @(posedge clk_in) begin
    if (srst_in || (conv_busy_out && !busy_reg)) begin
      cnt_reg <= 7'h00;
    end else if (conv_busy_out && conv_clk_in && !cc_reg) begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // =====
  oe_pin_a: assert property (serial_out_oe_out == !select_n_in)
    else $error("output enable differs from select");
  conv_len_a: assert property ($rose(result_valid_out) |-> cnt_reg inside {[48:64]})
    else $error("conversion length out of range");
  out_low_a: assert property (conv_busy_out && $past(conv_busy_out) && !select_n_in
    |-> !serial_out_out)
    else $error("serial output high during conversion");
  chan_hold_a: assert property (conv_busy_out |-> $stable(channel_out))
    else $error("channel changed during conversion");
  hold_start_a: assert property ($rose(conv_busy_out) |-> !sample_out)
    else $error("still sampling at conversion start");
  read_once_a: assert property ($rose(conv_busy_out) |-> !result_valid_out)
    else $error("result still valid after read");
  test_code_a: assert property ($rose(test_mode_out) |-> channel_out[3:2] == 2'b11)
    else $error("test mode without its code");
  test_pins_a: assert property (lowest_analog_inputs_oe_out == {4{test_mode_out}})
    else $error("pin enables differ from test mode");
  cover property ($rose(test_mode_out));
  cover property ($rose(result_valid_out));
  cover property ($fell(conv_busy_out) && !result_valid_out);
endmodule

bind sas_sequencer sas_sequencer_checker chk (
  .clk_in, .srst_in, .conv_clk_in, .select_n_in, .serial_out_out, .serial_out_oe_out,
  .channel_out, .sample_out, .conv_busy_out, .result_valid_out, .test_mode_out,
  .lowest_analog_inputs_oe_out
);

// >>> testbench/tb.sv
// Testbench of the converter sequencer with host and comparator models
`timescale 1ns/1ns
`include "sas_map.svh"
module tb;
  logic       clk_in, srst_in, ce_in, conv_clk_in, comp_in, select_n_in, sclk_in;
  logic       serial_in_in, serial_out_out, serial_out_oe_out, sample_out;
  logic       conv_busy_out, result_valid_out, test_mode_out;
  logic [7:0] approximation_register_out;
  logic [3:0] channel_out, lowest_analog_inputs_out, lowest_analog_inputs_oe_out;
  logic [8:0] d;
  int         failures, num_checks, seed, ana, n;
  int         q[$];

  always #10 clk_in = ~clk_in;
  always #100 conv_clk_in = ~conv_clk_in;
  // Comparator model: high while the input is at or above the trial code
  always @(negedge clk_in) comp_in <= (ana[7:0] >= approximation_register_out);

  sas_sequencer uut (
    .clk_in, .srst_in, .ce_in, .conv_clk_in, .select_n_in, .sclk_in, .serial_in_in,
    .comp_in, .serial_out_out, .serial_out_oe_out, .approximation_register_out,
    .channel_out, .sample_out, .conv_busy_out, .result_valid_out, .test_mode_out,
    .lowest_analog_inputs_out, .lowest_analog_inputs_oe_out
  );
  sas_host_model host (
    .serial_out_in(serial_out_out),
    .select_n_out (select_n_in),
    .sclk_out     (sclk_in),
    .serial_in_out(serial_in_in)
  );

  // =====
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_busy(input logic v);
    n = 0;
    while (conv_busy_out !== v && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
    chk("busy", v, conv_busy_out);
  endtask
  task automatic one(input bit keep, input bit ab);
    logic [7:0] a;
    int         e;
    logic [7:0] t;
    a = 8'($random(seed));
    if (keep) begin
      a[7:6] = 2'b11;
    end
    e = q.pop_front();
    host.xfer(a, keep, d);
    // Held select returns at the eighth fall; let the done flag cross first
    repeat (4) @(negedge clk_in);
    if (e >= 0) begin
      chk("result", e[7:0], d[8:1]);
    end
    chk("addr_echo", a[7], d[0]);
    chk("sample", 1'b1, sample_out);
    chk("channel", a[7:4], channel_out);
    chk("test_mode", a[7:6] == 2'b11, test_mode_out);
    ana = $random(seed);
    wait_busy(1'b1);
    chk("oe", keep, serial_out_oe_out);
    if (keep) begin
      chk("out_low", 1'b0, serial_out_out);
    end
    if (ab) begin
      host.set_sel(1'b0, 1000);
      wait_busy(1'b0);
      chk("valid", 1'b0, result_valid_out);
      q.push_back(-1); // Next result unreliable
    end else begin
      if (!keep) begin
        // Clock enable low must freeze the approximation mid-conversion
        @(negedge clk_in);
        ce_in = 1'b0;
        t = approximation_register_out;
        repeat (20) @(negedge clk_in);
        chk("frozen", t, approximation_register_out);
        chk("frozen_busy", 1'b1, conv_busy_out);
        ce_in = 1'b1;
        // Select spike shorter than a conversion clock
        host.set_sel(1'b0, 50);
        host.set_sel(1'b1, 0);
      end
      wait_busy(1'b0);
      repeat (3) @(negedge clk_in);
      chk("valid", 1'b1, result_valid_out);
      q.push_back(ana[7:0]);
      if (test_mode_out) begin
        chk("pins", ana[3:0], lowest_analog_inputs_out);
      end
      if (keep) begin
        #2000;
        chk("new_msb", ana[7], serial_out_out);
      end
    end
    $display("exchange %h done", a);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // =====
  initial begin
    clk_in = 1'b0;
    conv_clk_in = 1'b0;
    srst_in = 1'b1;
    ce_in = 1'b1;
    failures = 0;
    num_checks = 0;
    seed = 38804;
    ana = 0;
    q.push_back(`SAS_RESULT_RST);
    repeat (6) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (3) one(1'b0, 1'b0);
    one(1'b1, 1'b0);
    one(1'b0, 1'b0);
    one(1'b0, 1'b1);
    repeat (3) one(1'b0, 1'b0);
    test_done();
  end
  // Nine exchanges need well under half of this span
  initial begin
    #1000000;
    failures++;
    $display("mismatch watchdog expected done seen hang");
    test_done();
  end
endmodule
